// ===== verilog/pst_selftest.sv
// pst_selftest: prbs packet generator/checker control, error counter, loopback select, apb registers
// assumes a serial tx/rx bit path inside the phy, synchronous to mclk_i, one bit per clock
//
// How it works
// - continuous mode: pulse at max, restart zero
// - single mode: errors stop counting at max
// - prbs type plus enable: endless prbs packets
// - prbs type, generator off: checker stays active
// - constant type: one constant packet, no prbs
// - enable bit starts generator, clear stops it
// - lock bit reads checker lock state
// - sync-loss bit latches on lost sync
// - status bit shows generator active
// - loopback field selects data path
// - line transmit bit only in mac loopback
// - reserved bits read 10 and 00
`timescale 1ns/1ps
module pst_selftest #(
  parameter int ERR_W   = pst_pkg::ERR_W_DEF,
  parameter int PKT_LEN = pst_pkg::PKT_LEN_DEF,
  parameter int IFG     = pst_pkg::IFG_DEF
) (
  // clock and reset
  input  wire logic             mclk_i,
  input  wire logic             rstn_i,
  // apb slave
  input  wire logic             psel_i,
  input  wire logic             penable_i,
  input  wire logic             pwrite_i,
  input  wire logic [7:0]       paddr_i,
  input  wire logic [31:0]      pwdata_i,
  output logic      [31:0]      prdata_o,
  output logic                  pready_o,
  output logic                  pslverr_o,
  // transmit and receive bit path
  output logic                  tx_bit_o,
  output logic                  tx_en_o,
  input  wire logic             rx_bit_i,
  input  wire logic             rx_dv_i,
  // path select, events
  output pst_pkg::pst_lb_t      lb_o,
  output logic                  err_wrap_o,
  output logic                  irq_o
);
  // elaboration-time refusal of sizes the counters cannot hold
  if (ERR_W < 2 || ERR_W > 16 || PKT_LEN < 2 || PKT_LEN > 65535 || IFG < 1 || IFG > 65535) begin : g_bad_param
    $error("pst_selftest: parameter out of range");
  end

  localparam logic [ERR_W-1:0] ERR_MAX  = '1;
  localparam logic [15:0]      PKT_LAST = 16'(PKT_LEN - 1);
  localparam logic [15:0]      IFG_LAST = 16'(IFG - 1);
  localparam logic [4:0]       GOOD_N   = 5'(pst_pkg::LOCK_GOOD);
  localparam logic [2:0]       BAD_N    = 3'(pst_pkg::LOSS_BAD);
  localparam int               IRQ_W_L  = pst_pkg::IRQ_W;

  // control fields
  logic                  cnt_mode;
  logic                  pkt_type;
  logic                  gen_en;
  logic                  mac_tx;
  logic [3:0]            lb_sel;
  // status
  logic                  lock;
  logic                  loss;
  logic                  gen_st;
  logic [ERR_W-1:0]      err_cnt;
  logic [IRQ_W_L-1:0]    irq_st;
  logic [IRQ_W_L-1:0]    irq_mask;

  // apb decode; one wait state, write/read take effect when pready is seen high
  logic        req;
  logic        acc;
  logic        wr_ctrl;
  logic        rd_ctrl;
  logic        wr_err;
  logic        wr_st;
  logic        wr_mask;
  logic [15:0] ctrl_word;
  assign req     = psel_i & penable_i & ~pready_o;
  assign acc     = psel_i & penable_i & pready_o;
  assign wr_ctrl = acc & pwrite_i & (paddr_i == pst_pkg::ADDR_CTRL);
  assign rd_ctrl = acc & ~pwrite_i & (paddr_i == pst_pkg::ADDR_CTRL);
  assign wr_err  = acc & pwrite_i & (paddr_i == pst_pkg::ADDR_ERRCNT);
  assign wr_st   = acc & pwrite_i & (paddr_i == pst_pkg::ADDR_IRQ_ST);
  assign wr_mask = acc & pwrite_i & (paddr_i == pst_pkg::ADDR_IRQ_MASK);
  // reserved 15 and 1:0 read zero, 8:7 read fixed 10
  assign ctrl_word = {1'b0, cnt_mode, pkt_type, gen_en, lock, loss, gen_st,
                      pst_pkg::RSV_HI_VAL, mac_tx, lb_sel, 2'h0};

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0;
    end else begin
      pready_o  <= req;
      pslverr_o <= 1'b0;
      if (req) begin
        prdata_o <= 32'h0;
        unique case (paddr_i)
          pst_pkg::ADDR_CTRL:     prdata_o <= {16'h0, ctrl_word};
          pst_pkg::ADDR_ERRCNT:   prdata_o <= 32'(err_cnt);
          pst_pkg::ADDR_IRQ_ST:   prdata_o <= 32'(irq_st);
          pst_pkg::ADDR_IRQ_MASK: prdata_o <= 32'(irq_mask);
          default:                pslverr_o <= 1'b1;
        endcase
      end
    end
  end

  // control register
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_mode <= 1'b0;
      pkt_type <= 1'b0;
      gen_en   <= 1'b0;
      mac_tx   <= 1'b0;
      lb_sel   <= pst_pkg::LB_NORMAL;
    end else if (wr_ctrl) begin
      cnt_mode <= pwdata_i[pst_pkg::CNT_MODE_BIT];
      pkt_type <= pwdata_i[pst_pkg::PKT_TYPE_BIT];
      gen_en   <= pwdata_i[pst_pkg::GEN_EN_BIT];
      lb_sel   <= pwdata_i[pst_pkg::LB_LSB +: 4];
      // refused outside mac loopback, dropped when leaving it
      mac_tx   <= pwdata_i[pst_pkg::MAC_TX_BIT] & (pwdata_i[pst_pkg::LB_LSB +: 4] == pst_pkg::LB_MAC);
    end
  end

  // loopback path decode; reserved codes fall back to normal path
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lb_o <= '0;
    end else begin
      lb_o.pcs     <= (lb_sel == pst_pkg::LB_PCS);
      lb_o.analog  <= (lb_sel == pst_pkg::LB_ANALOG);
      lb_o.reverse <= (lb_sel == pst_pkg::LB_REVERSE);
      lb_o.mac     <= (lb_sel == pst_pkg::LB_MAC);
      lb_o.mac_tx  <= mac_tx;
    end
  end

  // packet generator
  pst_pkg::pst_gen_state_t gen_state;
  pst_pkg::pst_gen_state_t next_gen_state;
  logic [15:0]             gen_cnt;
  logic [15:0]             next_gen_cnt;
  logic [6:0]              tx_lfsr;

  always_comb begin
    next_gen_state = gen_state;
    next_gen_cnt   = gen_cnt + 16'h1;
    unique case (gen_state)
      pst_pkg::GEN_IDLE: begin
        next_gen_cnt = 16'h0;
        if (gen_en) next_gen_state = pst_pkg::GEN_PKT;
      end
      pst_pkg::GEN_PKT: begin
        if (gen_cnt == PKT_LAST) begin
          next_gen_cnt   = 16'h0;
          next_gen_state = pkt_type ? pst_pkg::GEN_GAP : pst_pkg::GEN_DONE;
        end
      end
      pst_pkg::GEN_GAP: begin
        if (gen_cnt == IFG_LAST) begin
          next_gen_cnt   = 16'h0;
          next_gen_state = pst_pkg::GEN_PKT;
        end
      end
      pst_pkg::GEN_DONE: begin
        next_gen_cnt = 16'h0;
        // switching to prbs type while enabled restarts the endless series
        if (pkt_type) next_gen_state = pst_pkg::GEN_PKT;
      end
    endcase
    if (!gen_en) begin
      next_gen_state = pst_pkg::GEN_IDLE;
      next_gen_cnt   = 16'h0;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      gen_state <= pst_pkg::GEN_IDLE;
      gen_cnt   <= 16'h0;
      gen_st    <= 1'b0;
      tx_en_o   <= 1'b0;
      tx_bit_o  <= 1'b0;
      tx_lfsr   <= pst_pkg::PRBS_SEED;
    end else begin
      gen_state <= next_gen_state;
      gen_cnt   <= next_gen_cnt;
      gen_st    <= (next_gen_state == pst_pkg::GEN_PKT) || (next_gen_state == pst_pkg::GEN_GAP);
      tx_en_o   <= (next_gen_state == pst_pkg::GEN_PKT);
      tx_bit_o  <= 1'b0;
      if (next_gen_state == pst_pkg::GEN_PKT) begin
        tx_bit_o <= pkt_type ? tx_lfsr[6] : pst_pkg::CONST_BIT;
        if (pkt_type) tx_lfsr <= {tx_lfsr[5:0], tx_lfsr[6] ^ tx_lfsr[5]};
      end
    end
  end

  // self-synchronising prbs7 checker, active whenever the prbs type is chosen
  logic       chk_on;
  logic [6:0] rx_sr;
  logic [4:0] good_cnt;
  logic [2:0] bad_cnt;
  logic       miss;
  logic       loss_evt;
  logic       lock_evt;
  logic       cnt_hit;
  assign chk_on   = pkt_type & rx_dv_i;
  assign miss     = chk_on & ((rx_sr[6] ^ rx_sr[5]) != rx_bit_i);
  assign loss_evt = miss & lock & (bad_cnt == BAD_N - 3'h1);
  assign lock_evt = chk_on & ~miss & ~lock & (good_cnt == GOOD_N - 5'h1);
  assign cnt_hit  = miss & lock;

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_sr    <= 7'h0;
      good_cnt <= 5'h0;
      bad_cnt  <= 3'h0;
      lock     <= 1'b0;
    end else if (!pkt_type) begin
      good_cnt <= 5'h0;
      bad_cnt  <= 3'h0;
      lock     <= 1'b0;
    end else if (rx_dv_i) begin
      rx_sr <= {rx_sr[5:0], rx_bit_i};
      if (miss) begin
        good_cnt <= 5'h0;
        bad_cnt  <= loss_evt ? 3'h0 : bad_cnt + 3'h1;
        if (loss_evt) lock <= 1'b0;
      end else begin
        bad_cnt <= 3'h0;
        if (!lock) good_cnt <= good_cnt + 5'h1;
        if (lock_evt) lock <= 1'b1;
      end
    end
  end

  // sync-loss latch: a new loss in the clearing read's cycle wins
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) loss <= 1'b0;
    else         loss <= loss_evt | (loss & ~rd_ctrl);
  end

  // error counter; a write to it clears it, as does the next error at max once continuous mode is set after a single-mode stop
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      err_cnt    <= '0;
      err_wrap_o <= 1'b0;
    end else begin
      err_wrap_o <= cnt_hit & cnt_mode & (err_cnt == ERR_MAX);
      if (wr_err) err_cnt <= '0;
      else if (cnt_hit && err_cnt != ERR_MAX) err_cnt <= err_cnt + 1'b1;
      else if (cnt_hit && cnt_mode) err_cnt <= '0;
    end
  end

  // interrupts: sticky, write one to clear, set wins over clear
  logic [IRQ_W_L-1:0] irq_evt;
  logic [IRQ_W_L-1:0] next_irq_st;
  always_comb begin
    irq_evt                    = '0;
    irq_evt[pst_pkg::IRQ_LOSS] = loss_evt;
    irq_evt[pst_pkg::IRQ_WRAP] = cnt_hit & cnt_mode & (err_cnt == ERR_MAX);
    irq_evt[pst_pkg::IRQ_LOCK] = lock_evt;
    next_irq_st = (irq_st & ~(wr_st ? pwdata_i[IRQ_W_L-1:0] : '0)) | irq_evt;
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_st   <= '0;
      irq_mask <= '0;
      irq_o    <= 1'b0;
    end else begin
      irq_st   <= next_irq_st;
      if (wr_mask) irq_mask <= pwdata_i[IRQ_W_L-1:0];
      irq_o    <= |(next_irq_st & (wr_mask ? pwdata_i[IRQ_W_L-1:0] : irq_mask));
    end
  end

  // checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  a_wrap_restart: assert property (cnt_hit && cnt_mode && err_cnt == ERR_MAX && !wr_err
    |=> err_cnt == '0 && err_wrap_o) else $error("continuous counter did not wrap with pulse");
  a_single_stop: assert property (cnt_hit && !cnt_mode && err_cnt == ERR_MAX && !wr_err
    |=> err_cnt == ERR_MAX && !err_wrap_o) else $error("single-mode counter moved past max");
  a_prbs_repeat: assert property ($fell(tx_en_o) && gen_en && pkt_type && $past(gen_en)
    |-> gen_state == pst_pkg::GEN_GAP) else $error("prbs packets did not continue");
  a_check_live: assert property (pkt_type && rx_dv_i
    |=> rx_sr == {$past(rx_sr[5:0]), $past(rx_bit_i)}) else $error("checker idle with prbs type");
  a_const_data: assert property (!$past(pkt_type) && tx_en_o |-> tx_bit_o == pst_pkg::CONST_BIT)
    else $error("constant packet carried prbs data");
  a_const_nochk: assert property (!pkt_type |=> !lock) else $error("checker locked with constant type");
  a_gen_off: assert property (!gen_en |=> !tx_en_o && !gen_st) else $error("generator ran while disabled");
  a_lock_read: assert property (pready_o && $past(req && !pwrite_i && paddr_i == pst_pkg::ADDR_CTRL)
    |-> prdata_o[pst_pkg::LOCK_BIT] == $past(lock)) else $error("lock bit misreported");
  a_loss_latch: assert property (loss_evt |=> loss ##1 (loss || $past(rd_ctrl)))
    else $error("sync loss not latched");
  a_gen_status: assert property ($past(gen_en && pkt_type) |-> gen_st)
    else $error("generator status disagrees with generator");
  a_lb_decode: assert property (lb_sel == pst_pkg::LB_PCS |=> lb_o.pcs && !lb_o.analog && !lb_o.reverse)
    else $error("pcs loopback not selected");
  a_mac_only: assert property (mac_tx |-> lb_sel == pst_pkg::LB_MAC)
    else $error("line transmit bit set outside mac loopback");
  a_rsv_read: assert property (pready_o && $past(req && paddr_i == pst_pkg::ADDR_CTRL)
    |-> prdata_o[8:7] == 2'h2 && prdata_o[1:0] == 2'h0) else $error("reserved bits misread");
  a_loss_clear: assert property (loss && rd_ctrl && !loss_evt |=> !loss)
    else $error("sync loss not cleared by read");

  c_lock_gain: cover property (lock_evt);
  c_cont_wrap: cover property (err_wrap_o);
  c_loss_irq:  cover property (loss_evt ##1 irq_o);
  c_two_pkts:  cover property ($fell(tx_en_o) ##[1:100] $rose(tx_en_o));
endmodule : pst_selftest

// ===== verilog/pst_pkg.sv
// pst_pkg: register map, field layout, counts and carrier types of the prbs self-test block
// assumes a 32-bit apb slave with one aligned word per register
package pst_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_ERRCNT   = 8'h04;
  localparam logic [7:0] ADDR_IRQ_ST   = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
  // self_test_control field positions
  localparam int CNT_MODE_BIT = 14;
  localparam int PKT_TYPE_BIT = 13;
  localparam int GEN_EN_BIT   = 12;
  localparam int LOCK_BIT     = 11;
  localparam int LOSS_BIT     = 10;
  localparam int GEN_ST_BIT   = 9;
  localparam int MAC_TX_BIT   = 6;
  localparam int LB_LSB       = 2;
  localparam logic [1:0] RSV_HI_VAL = 2'h2;
  // loopback select codes
  localparam logic [3:0] LB_NORMAL = 4'h0;
  localparam logic [3:0] LB_PCS    = 4'h1;
  localparam logic [3:0] LB_ANALOG = 4'h2;
  localparam logic [3:0] LB_REVERSE = 4'h4;
  localparam logic [3:0] LB_MAC    = 4'h8;
  // interrupt status / mask bits
  localparam int IRQ_W    = 3;
  localparam int IRQ_LOSS = 0;
  localparam int IRQ_WRAP = 1;
  localparam int IRQ_LOCK = 2;
  // prbs7 seed, constant payload bit, checker thresholds, packet shape
  localparam logic [6:0] PRBS_SEED = 7'h7F;
  localparam logic       CONST_BIT = 1'b1;
  localparam int LOCK_GOOD   = 16;
  localparam int LOSS_BAD    = 4;
  localparam int PKT_LEN_DEF = 64;
  localparam int IFG_DEF     = 12;
  localparam int ERR_W_DEF   = 8;

  typedef struct packed {
    logic       pcs;
    logic       analog;
    logic       reverse;
    logic       mac;
    logic       mac_tx;
  } pst_lb_t;

  typedef enum logic [1:0] {GEN_IDLE, GEN_PKT, GEN_GAP, GEN_DONE} pst_gen_state_t;
endpackage : pst_pkg

// ===== testbench/pst_selftest_tb.sv
// pst_selftest_tb: self-checking bench for the prbs self-test block
// assumes it is the only apb master and loops tx back to rx with injected bit errors
`timescale 1ns/1ps
module pst_selftest_tb;
  localparam int PL = 24;
  localparam int IG = 4;
  localparam int EW = 2;
  localparam logic [31:0] B_MODE = 32'h4000;
  localparam logic [31:0] B_TYPE = 32'h2000;
  localparam logic [31:0] B_GEN  = 32'h1000;
  localparam logic [31:0] B_LOCK = 32'h0800;
  localparam logic [31:0] B_LOSS = 32'h0400;
  localparam logic [31:0] B_STAT = 32'h0200;
  localparam logic [31:0] ALL    = 32'hFFFFFFFF;

  typedef struct packed {
    logic [31:0] d;
    logic [31:0] m;
    logic        e;
  } pst_exp_t;

  logic             mclk_i = 1'b0;
  logic             rstn_i, psel_i, penable_i, pwrite_i, rx_bit_i, rx_dv_i;
  logic [7:0]       paddr_i;
  logic [31:0]      pwdata_i, prdata_o;
  logic             pready_o, pslverr_o, tx_bit_o, tx_en_o, err_wrap_o, irq_o;
  pst_pkg::pst_lb_t lb_o;
  int               num_errors = 0, compares = 0, seed = 44920, cyc = 0, rnd, hi, lo;
  pst_exp_t         exp_q[$];
  logic             loop_on = 1'b0, inj_on = 1'b0, burst = 1'b0, wrap_seen = 1'b0, flip, ones;
  logic             jam = 1'b0;
  logic [3:0]       spc = 4'h0;
  logic [3:0]       codes[5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8};

  always #12.5 mclk_i = ~mclk_i;

  pst_selftest #(.ERR_W(EW), .PKT_LEN(PL), .IFG(IG)) DUT (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .tx_bit_o(tx_bit_o), .tx_en_o(tx_en_o), .rx_bit_i(rx_bit_i), .rx_dv_i(rx_dv_i), .lb_o(lb_o),
    .err_wrap_o(err_wrap_o), .irq_o(irq_o));

  task automatic test_done;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done

  task automatic chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk

  // one transfer; the expectation is queued for the response monitor
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e,
                     input logic [31:0] m, input logic er);
    int n;
    n = 0;
    exp_q.push_back('{e, m, er});
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge mclk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (n >= 20) chk(1'b0, "apb no ready");
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge mclk_i);
  endtask : apb

  // length of the next packet and of the gap after it
  task automatic pkt;
    int n;
    n = 0;
    hi = 0;
    lo = 0;
    ones = 1'b1;
    while (tx_en_o !== 1'b1 && n < 200) begin
      @(posedge mclk_i);
      n++;
    end
    while (tx_en_o === 1'b1 && hi < 500) begin
      ones = ones & (tx_bit_o === 1'b1);
      hi++;
      @(posedge mclk_i);
    end
    while (tx_en_o !== 1'b1 && lo < 500) begin
      lo++;
      @(posedge mclk_i);
    end
  endtask : pkt

  always @(posedge mclk_i) begin
    if (pready_o === 1'b1) begin
      if (exp_q.size() == 0) chk(1'b0, "unexpected ready");
      else begin
        pst_exp_t x;
        x = exp_q.pop_front();
        chk(((prdata_o & x.m) === (x.d & x.m)) && (pslverr_o === x.e), "apb response");
      end
    end
  end

  // error spacing keeps one flip from looking like a burst to the checker
  always @(posedge mclk_i) begin
    rnd = $random(seed);
    flip = burst | (inj_on & (spc == 4'h0) & (rnd[2:0] == 3'h0));
    spc <= flip ? 4'hF : ((spc != 4'h0) ? spc - 4'h1 : spc);
    // jam: steady ones break the prbs recurrence with the generator off
    rx_dv_i <= (tx_en_o & loop_on) | jam;
    rx_bit_i <= (tx_bit_o ^ flip) | jam;
    if (err_wrap_o === 1'b1) wrap_seen <= 1'b1;
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      chk(1'b0, "timeout");
      test_done();
    end
  end

  initial begin
    rstn_i = 1'b0;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 8'h00;
    pwdata_i = 32'h00000000;
    rx_bit_i = 1'b0;
    rx_dv_i = 1'b0;
    repeat (3) @(posedge mclk_i);
    rstn_i <= 1'b1;
    @(posedge mclk_i);
    apb(1'b0, pst_pkg::ADDR_CTRL, 32'h0, 32'h00000100, ALL, 1'b0);
    apb(1'b0, 8'h10, 32'h0, 32'h0, ALL, 1'b1);
    apb(1'b1, 8'h14, 32'h0, 32'h0, 32'h0, 1'b1);
    loop_on <= 1'b1;
    apb(1'b1, pst_pkg::ADDR_IRQ_MASK, 32'h7, 32'h0, 32'h0, 1'b0);
    apb(1'b1, pst_pkg::ADDR_CTRL, B_TYPE | B_GEN, 32'h0, 32'h0, 1'b0);
    pkt();
    chk(hi == PL && lo == IG, "prbs packet shape");
    pkt();
    chk(hi == PL && lo == IG, "prbs second packet");
    apb(1'b0, pst_pkg::ADDR_CTRL, 32'h0, B_LOCK | B_STAT, B_LOCK | B_LOSS | B_STAT, 1'b0);
    apb(1'b0, pst_pkg::ADDR_IRQ_ST, 32'h0, 32'h4, 32'h7, 1'b0);
    chk(irq_o === 1'b1, "irq on lock");
    apb(1'b1, pst_pkg::ADDR_IRQ_ST, 32'h4, 32'h0, 32'h0, 1'b0);
    repeat (2) @(posedge mclk_i);
    chk(irq_o === 1'b0, "irq after clear");
    inj_on <= 1'b1;
    repeat (400) @(posedge mclk_i);
    inj_on <= 1'b0;
    apb(1'b0, pst_pkg::ADDR_ERRCNT, 32'h0, 32'h3, 32'hFF, 1'b0);
    chk(wrap_seen === 1'b0, "wrap in single mode");
    apb(1'b1, pst_pkg::ADDR_ERRCNT, 32'h0, 32'h0, 32'h0, 1'b0);
    apb(1'b1, pst_pkg::ADDR_CTRL, B_MODE | B_TYPE | B_GEN, 32'h0, 32'h0, 1'b0);
    inj_on <= 1'b1;
    repeat (400) @(posedge mclk_i);
    inj_on <= 1'b0;
    chk(wrap_seen === 1'b1, "no wrap pulse");
    apb(1'b0, pst_pkg::ADDR_IRQ_ST, 32'h0, 32'h2, 32'h2, 1'b0);
    apb(1'b1, pst_pkg::ADDR_IRQ_ST, 32'h7, 32'h0, 32'h0, 1'b0);
    burst <= 1'b1;
    repeat (16) @(posedge mclk_i);
    burst <= 1'b0;
    repeat (50) @(posedge mclk_i);
    apb(1'b0, pst_pkg::ADDR_CTRL, 32'h0, B_LOSS, B_LOSS, 1'b0);
    apb(1'b0, pst_pkg::ADDR_CTRL, 32'h0, 32'h0, B_LOSS, 1'b0);
    apb(1'b0, pst_pkg::ADDR_IRQ_ST, 32'h0, 32'h1, 32'h1, 1'b0);
    apb(1'b1, pst_pkg::ADDR_IRQ_MASK, 32'h0, 32'h0, 32'h0, 1'b0);
    repeat (2) @(posedge mclk_i);
    chk(irq_o === 1'b0, "masked irq");
    apb(1'b1, pst_pkg::ADDR_IRQ_MASK, 32'h7, 32'h0, 32'h0, 1'b0);
    repeat (2) @(posedge mclk_i);
    chk(irq_o === 1'b1, "unmasked irq");
    apb(1'b1, pst_pkg::ADDR_IRQ_ST, 32'h7, 32'h0, 32'h0, 1'b0);
    repeat (2) @(posedge mclk_i);
    chk(irq_o === 1'b0, "irq after w1c");
    apb(1'b1, pst_pkg::ADDR_CTRL, B_TYPE, 32'h0, 32'h0, 1'b0);
    repeat (2) @(posedge mclk_i);
    chk(tx_en_o === 1'b0, "tx after disable");
    jam <= 1'b1;
    repeat (16) @(posedge mclk_i);
    jam <= 1'b0;
    repeat (2) @(posedge mclk_i);
    apb(1'b0, pst_pkg::ADDR_CTRL, 32'h0, B_LOSS, B_LOCK | B_LOSS | B_STAT, 1'b0);
    // mac_tx set with every code: only the mac code may keep it
    foreach (codes[i]) begin
      apb(1'b1, pst_pkg::ADDR_CTRL, {26'h0, codes[i], 2'h0} | 32'h40, 32'h0, 32'h0, 1'b0);
      repeat (2) @(posedge mclk_i);
      chk(lb_o === pst_pkg::pst_lb_t'{codes[i] == pst_pkg::LB_PCS, codes[i] == pst_pkg::LB_ANALOG,
          codes[i] == pst_pkg::LB_REVERSE, codes[i] == pst_pkg::LB_MAC, codes[i] == pst_pkg::LB_MAC},
          "loopback path");
    end
    apb(1'b1, pst_pkg::ADDR_CTRL, B_GEN, 32'h0, 32'h0, 1'b0);
    pkt();
    chk(hi == PL && ones === 1'b1 && lo == 500, "single constant packet");
    test_done();
  end
endmodule : pst_selftest_tb
